// ---- include/scm_pkg.sv ----
// package: register map, field layout and link constants of the serial mode control block
package scm_pkg;

  localparam logic [7:0] SCM_MODE1_OFFSET = 8'h00;
  localparam logic [7:0] SCM_STATUS_OFFSET = 8'h04;

  localparam int SCM_IDLE_BIT = 7;
  localparam int SCM_DIR_LSB = 5;
  localparam int SCM_TXE_BIT = 4;
  localparam int SCM_INT_LSB = 1;

  localparam int SCM_STAT_GAP_BIT = 0;
  localparam int SCM_STAT_RUN_BIT = 1;
  localparam int SCM_STAT_TX_BIT = 2;

  localparam logic [6:0] SCM_MODE1_RESET = 7'h00;

  localparam logic [1:0] SCM_DIR_BLOCKED = 2'h0;
  localparam logic [1:0] SCM_DIR_RX = 2'h1;
  localparam logic [1:0] SCM_DIR_TX = 2'h2;
  localparam logic [1:0] SCM_DIR_FULL = 2'h3;

  localparam logic [2:0] SCM_INT_NONE = 3'h0;
  localparam int SCM_GAP_CNT_W = 7;

  typedef struct packed {
    logic idle_operation_select;
    logic [1:0] transfer_direction_field;
    logic transmit_enable_bit;
    logic [2:0] frame_interval_field;
  } scm_mode_type;

  typedef struct packed {
    logic sync_mode;
    logic sclk_internal;
    logic dbuf_enable;
    logic fifo_enable;
  } scm_cfg_type;

  typedef enum logic [1:0] {
    SCM_LINK_READY = 2'b01,
    SCM_LINK_GAP = 2'b10
  } scm_link_state_type;

endpackage

// ---- hdl/scm_ctrl.sv ----
// serial channel mode control register with inter-frame gap timing on the link clock

// Overview of operation
// - Bit 7 chooses whether the channel halts or keeps running while the chip is idle.
// - In synchronous mode bits 6-5 select blocked, receive-only, transmit-only or full duplex.
// - With the FIFO on, bits 6-5 also set its configuration, and in UART mode they set only that.
// - Bit 4 allows transmission when set and blocks it when clear, in every transfer mode.
// - Bits 3-1 give a gap of none, or 1, 2, 4, 8, 16, 32 or 64 serial clocks between frames.
// - The gap applies only in synchronous mode with internal serial clock and double buffer or FIFO.
module scm_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire scm_pkg::scm_cfg_type cfg,
  input wire logic chip_idle,
  output logic run_enable,
  output logic rx_enable,
  output logic tx_enable,
  output logic [1:0] fifo_cfg,
  input wire logic link_clk,
  input wire logic link_frame_end,
  output logic link_tx_permit,
  output logic link_gap_active
);

  scm_pkg::scm_mode_type mode, next_mode;
  logic [31:0] next_rdata;
  logic next_run, next_rx, next_tx, next_gap_en, gap_en;
  logic [1:0] next_fifo_cfg;
  logic gap_busy_s1, gap_busy_s2;

  // register port and mode decoding, system clock
  always_comb
  begin
    next_mode = mode;
    next_rdata = 32'h0;
    if (reg_wr && reg_addr == scm_pkg::SCM_MODE1_OFFSET)
    begin
      next_mode = reg_wdata[7:1];
    end
    if (reg_rd && reg_addr == scm_pkg::SCM_MODE1_OFFSET)
    begin
      next_rdata = {24'h0, mode, 1'b0};
    end
    else if (reg_rd && reg_addr == scm_pkg::SCM_STATUS_OFFSET)
    begin
      next_rdata[scm_pkg::SCM_STAT_GAP_BIT] = gap_busy_s2;
      next_rdata[scm_pkg::SCM_STAT_RUN_BIT] = run_enable;
      next_rdata[scm_pkg::SCM_STAT_TX_BIT] = tx_enable;
    end
    next_run = !chip_idle || mode.idle_operation_select;
    // uart mode takes no direction from the field, only the fifo layout
    next_rx = next_run && (!cfg.sync_mode || mode.transfer_direction_field[0]);
    next_tx = next_run && mode.transmit_enable_bit
              && (!cfg.sync_mode || mode.transfer_direction_field[1]);
    next_fifo_cfg = cfg.fifo_enable ? mode.transfer_direction_field
                    : scm_pkg::SCM_DIR_BLOCKED;
    next_gap_en = cfg.sync_mode && cfg.sclk_internal
                  && (cfg.dbuf_enable || cfg.fifo_enable);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode <= scm_pkg::SCM_MODE1_RESET;
      reg_rdata <= 32'h0;
      run_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      fifo_cfg <= 2'h0;
      gap_en <= 1'b0;
      gap_busy_s1 <= 1'b0;
      gap_busy_s2 <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      reg_rdata <= next_rdata;
      run_enable <= next_run;
      rx_enable <= next_rx;
      tx_enable <= next_tx;
      fifo_cfg <= next_fifo_cfg;
      gap_en <= next_gap_en;
      gap_busy_s1 <= link_gap_active;
      gap_busy_s2 <= gap_busy_s1;
    end
  end

  // link domain: enables arrive through two flops each, the interval code through three
  logic txe_s1, txe_s2, gen_s1, gen_s2;
  logic [2:0] int_s1, int_s2, int_s3, int_stable, next_int_stable;
  scm_pkg::scm_link_state_type lstate, next_lstate;
  logic [scm_pkg::SCM_GAP_CNT_W-1:0] gap_cnt, next_gap_cnt;
  logic next_permit, next_gap_active, gap_go;

  // the code may be caught mid-change; it is only taken once two samples agree
  always_comb
  begin
    next_int_stable = (int_s2 == int_s3) ? int_s2 : int_stable;
    gap_go = link_frame_end && gen_s2 && int_stable != scm_pkg::SCM_INT_NONE;
    next_lstate = lstate;
    next_gap_cnt = gap_cnt;
    case (lstate)
      scm_pkg::SCM_LINK_READY:
      begin
        if (gap_go)
        begin
          next_lstate = scm_pkg::SCM_LINK_GAP;
          // codes 1..7 give 1,2,4..64 clocks; count runs down to zero
          next_gap_cnt = (7'h1 << (int_stable - 3'h1)) - 7'h1;
        end
      end
      scm_pkg::SCM_LINK_GAP:
      begin
        if (gap_cnt == 7'h0)
        begin
          next_lstate = scm_pkg::SCM_LINK_READY;
        end
        else
        begin
          next_gap_cnt = gap_cnt - 7'h1;
        end
      end
      default:
      begin
        next_lstate = scm_pkg::SCM_LINK_READY;
        next_gap_cnt = 7'h0;
      end
    endcase
    // clearing enable mid-frame cuts the permit at once; software must avoid it
    next_permit = txe_s2 && next_lstate == scm_pkg::SCM_LINK_READY;
    next_gap_active = next_lstate == scm_pkg::SCM_LINK_GAP;
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txe_s1 <= 1'b0;
      txe_s2 <= 1'b0;
      gen_s1 <= 1'b0;
      gen_s2 <= 1'b0;
      int_s1 <= 3'h0;
      int_s2 <= 3'h0;
      int_s3 <= 3'h0;
      int_stable <= 3'h0;
      lstate <= scm_pkg::SCM_LINK_READY;
      gap_cnt <= 7'h0;
      link_tx_permit <= 1'b0;
      link_gap_active <= 1'b0;
    end
    else
    begin
      txe_s1 <= tx_enable;
      txe_s2 <= txe_s1;
      gen_s1 <= gap_en;
      gen_s2 <= gen_s1;
      int_s1 <= mode.frame_interval_field;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
      int_stable <= next_int_stable;
      lstate <= next_lstate;
      gap_cnt <= next_gap_cnt;
      link_tx_permit <= next_permit;
      link_gap_active <= next_gap_active;
    end
  end

  // checks, system domain
  a_idle_halts: assert property (@(posedge clk) disable iff (sys_rst)
    chip_idle && !mode.idle_operation_select |=> !run_enable && !tx_enable && !rx_enable)
    else $error("channel runs in idle with halt selected");

  a_dir_rx_only: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.sync_mode && mode.transfer_direction_field == scm_pkg::SCM_DIR_RX && !chip_idle
    |=> rx_enable && !tx_enable)
    else $error("receive-only direction not honoured");

  a_fifo_layout: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.fifo_enable |=> fifo_cfg == $past(mode.transfer_direction_field))
    else $error("fifo layout does not follow direction field");

  a_txe_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    !mode.transmit_enable_bit |=> !tx_enable)
    else $error("transmit enabled with enable bit clear");

  a_mode_write: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == scm_pkg::SCM_MODE1_OFFSET |=> mode == $past(reg_wdata[7:1]))
    else $error("mode register write not stored");

  a_read_upper: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == scm_pkg::SCM_MODE1_OFFSET
    |=> reg_rdata[31:8] == 24'h0 && !reg_rdata[0] && reg_rdata[7:1] == $past(mode))
    else $error("mode register read data wrong");

  a_idle_keeps: assert property (@(posedge clk) disable iff (sys_rst)
    chip_idle && mode.idle_operation_select |=> run_enable)
    else $error("channel halted in idle with operate selected");

  a_awake_runs: assert property (@(posedge clk) disable iff (sys_rst)
    !chip_idle |=> run_enable)
    else $error("channel halted outside idle");

  a_dir_blocked: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.sync_mode && mode.transfer_direction_field == scm_pkg::SCM_DIR_BLOCKED
    |=> !rx_enable && !tx_enable)
    else $error("transfer allowed with direction blocked");

  a_dir_tx_only: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.sync_mode && mode.transfer_direction_field == scm_pkg::SCM_DIR_TX
    && !chip_idle && mode.transmit_enable_bit |=> tx_enable && !rx_enable)
    else $error("transmit-only direction not honoured");

  a_dir_full: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.sync_mode && mode.transfer_direction_field == scm_pkg::SCM_DIR_FULL
    && !chip_idle && mode.transmit_enable_bit |=> tx_enable && rx_enable)
    else $error("full duplex direction not honoured");

  a_uart_no_dir: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg.sync_mode && !chip_idle
    |=> rx_enable && tx_enable == $past(mode.transmit_enable_bit))
    else $error("direction field restricts transfers in uart mode");

  a_fifo_off: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg.fifo_enable |=> fifo_cfg == scm_pkg::SCM_DIR_BLOCKED)
    else $error("fifo layout set with fifo disabled");

  a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside the read cycle");

  // checks, link domain
  sequence s_gap_start;
    lstate == scm_pkg::SCM_LINK_READY && gap_go;
  endsequence

  sequence s_gap_hold;
    !link_tx_permit && link_gap_active;
  endsequence

  a_gap_begins: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_gap_start |=> s_gap_hold)
    else $error("gap not started after frame end");

  a_gap_one_clk: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_gap_start ##0 int_stable == 3'h1 |=> s_gap_hold ##1 !link_gap_active)
    else $error("single clock gap has wrong length");

  a_gap_bounded: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_gap_start |=> link_gap_active ##[1:64] !link_gap_active)
    else $error("gap longer than the largest interval");

  a_no_gap_off: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_frame_end && !gen_s2 && lstate == scm_pkg::SCM_LINK_READY |=> !link_gap_active)
    else $error("gap inserted outside synchronous clock output mode");

  // check helper: gap length in link clocks and the code it began with
  logic [7:0] gap_seen, next_gap_seen;
  logic [2:0] gap_code, next_gap_code;

  always_comb
  begin
    next_gap_seen = link_gap_active ? gap_seen + 8'h01 : 8'h00;
    next_gap_code = (lstate == scm_pkg::SCM_LINK_READY && gap_go) ? int_stable : gap_code;
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_seen <= 8'h00;
      gap_code <= 3'h0;
    end
    else
    begin
      gap_seen <= next_gap_seen;
      gap_code <= next_gap_code;
    end
  end

  sequence s_gap_end;
    $fell(link_gap_active);
  endsequence

  a_gap_length: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_gap_end |-> gap_seen == 8'h01 << (gap_code - 3'h1))
    else $error("gap length does not match the interval code");

  a_gap_two_clk: assert property (@(posedge link_clk) disable iff (sys_rst)
    s_gap_start ##0 int_stable == 3'h2 |=> s_gap_hold ##1 s_gap_hold ##1 !link_gap_active)
    else $error("two clock gap has wrong length");

  a_permit_blocked: assert property (@(posedge link_clk) disable iff (sys_rst)
    !txe_s2 |=> !link_tx_permit)
    else $error("frame permitted with transmit disabled");

  a_gap_only_sync: assert property (@(posedge link_clk) disable iff (sys_rst)
    !gen_s2 && !link_gap_active |=> !link_gap_active)
    else $error("gap started with gap timing disabled");

endmodule

// ---- test/scm_link_model.sv ----
// link-side shift engine model: one frame per request, then times the gap after it
module scm_link_model (
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic link_tx_permit,
  input wire logic link_gap_active,
  output logic link_frame_end,
  output logic [7:0] gap_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sent;
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sent <= 1'b0;
      link_frame_end <= 1'b0;
      gap_len <= 8'h00;
    end
    else
    begin
      // a frame starts only while permitted, as the real engine would
      link_frame_end <= go && !sent && link_tx_permit;
      if (go && !sent && link_tx_permit)
      begin
        sent <= 1'b1;
        gap_len <= 8'h00;
      end
      else if (!go)
        sent <= 1'b0;
      if (sent && link_gap_active)
        gap_len <= gap_len + 8'h01;
    end
  end
endmodule

// ---- test/scm_ctrl_test.sv ----
// register bench for the serial mode control block
module scm_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  scm_pkg::scm_cfg_type cfg = 4'h0;
  logic chip_idle = 1'b0;
  logic run_enable, rx_enable, tx_enable, frame_end, permit, gap, go = 1'b0;
  logic [1:0] fifo_cfg;
  logic [7:0] gap_len;
  logic [3:0] gcfg [4] = '{4'b1010, 4'b1100, 4'b1101, 4'b0111};
  logic [7:0] gexp [4] = '{8'h00, 8'h00, 8'h40, 8'h00};
  logic [4:0] e;
  int failures = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  // odd start offset keeps the two clocks out of phase
  initial
  begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  scm_ctrl scm_ctrl_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg(cfg), .chip_idle(chip_idle), .run_enable(run_enable), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .fifo_cfg(fifo_cfg), .link_clk(link_clk),
    .link_frame_end(frame_end), .link_tx_permit(permit), .link_gap_active(gap));
  scm_link_model scm_link_model_i (.link_clk(link_clk), .sys_rst(sys_rst), .go(go),
    .link_tx_permit(permit), .link_gap_active(gap), .link_frame_end(frame_end),
    .gap_len(gap_len));
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    // return on an edge so later stimulus stays edge aligned
    @(posedge clk);
  endtask
  task automatic wait_permit();
    int k;
    for (k = 0; k < 100 && permit !== 1'b1; k++)
      @(posedge clk);
    if (permit !== 1'b1)
    begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic frame(input logic [3:0] c, input logic [2:0] code, input logic [7:0] exp);
    cfg <= c;
    wr(8'h00, {24'h0, 1'b0, 2'b10, 1'b1, code, 1'b0});
    wait_permit();
    go <= 1'b1;
    repeat (60) @(posedge clk);
    go <= 1'b0;
    chk(gap_len, exp);
    wait_permit();
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, d);
    chk(d, 32'h0);
    wr(8'h00, 32'hffffffff);
    rd(8'h00, d);
    chk(d, 32'h000000fe);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    rd(8'h00, d);
    chk(d, 32'h000000fe);
    rd(8'h08, d);
    chk(d, 32'h0);
    rd(8'h04, d);
    chk(d, 32'h00000006);
    for (int i = 0; i < 64; i++)
    begin
      cfg <= {i[2], 2'b11, i[3]};
      chip_idle <= i[5];
      wr(8'h00, {24'h0, i[0], i[1:0], i[4], 4'h0});
      e[4] = i[0] | !i[5];
      e[3] = e[4] & (!i[2] | i[0]);
      e[2] = e[4] & i[4] & (!i[2] | i[1]);
      e[1:0] = i[3] ? i[1:0] : 2'b00;
      chk({27'h0, run_enable, rx_enable, tx_enable, fifo_cfg}, {27'h0, e});
    end
    chip_idle <= 1'b0;
    for (int c = 0; c < 8; c++)
      frame(4'b1110, c[2:0], c == 0 ? 8'h00 : 8'h01 << (c - 1));
    for (int j = 0; j < 4; j++)
      frame(gcfg[j], 3'h7, gexp[j]);
    wr(8'h00, 32'h00000000);
    repeat (4) @(posedge clk);
    chk({31'h0, permit}, 32'h0);
    wr(8'h00, 32'h000000f0);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, d);
    chk(d, 32'h0);
    give_verdict();
  end
endmodule
